//--- verilog/ssm_pkg.sv
// ==========================================================
// Shared constants for the scripted SPI master
package ssm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  // Basic transaction: chip select to first clock edge, in ns
  localparam int CS_LEAD_NS = 10000;
  localparam int CS_LEAD_CYC = (CS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Basic transaction: last clock edge to chip select release, in ns
  localparam int CS_TAIL_NS = 7800;
  localparam int CS_TAIL_CYC = (CS_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest serial clock period, in ns, and its half period in cycles
  localparam int SCLK_MAX_NS = 1000000;
  localparam int SCLK_MAX_HALF_CYC = SCLK_MAX_NS / CLK_PERIOD_NS / 2;

  // ==========================================================
  // Sizes
  localparam int CMD_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int MAX_READS = 64;
  localparam int SAMPLE_W = 16;
  localparam int NUM_CS = 8;

  // ==========================================================
  // Command word fields
  localparam int OP_LSB = 28;
  localparam int CS_SEL_LSB = 24;
  localparam int ARG_LSB = 0;
  localparam int CPOL_BIT = 1;
  localparam int CPHA_BIT = 0;

  // ==========================================================
  // Opcodes
  localparam logic [3:0] OP_ENABLE = 4'h1;
  localparam logic [3:0] OP_DISABLE = 4'h2;
  localparam logic [3:0] OP_POLPHA = 4'h3;
  localparam logic [3:0] OP_RATE = 4'h4;
  localparam logic [3:0] OP_BITS = 4'h5;
  localparam logic [3:0] OP_CS_LOW = 4'h6;
  localparam logic [3:0] OP_CS_HIGH = 4'h7;
  localparam logic [3:0] OP_WRRD = 4'h8;
  localparam logic [3:0] OP_BASIC = 4'h9;
  localparam logic [3:0] OP_END = 4'ha;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_HALF = 16'h0019;
  localparam logic [4:0] RST_BITS = 5'h08;
  localparam logic [4:0] BASIC_BITS = 5'h08;
  localparam logic RST_CPOL = 1'b0;
  localparam logic RST_CPHA = 1'b0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_LEAD, ST_BDATA, ST_SHIFT, ST_TAIL
  } ssm_state_t;

endpackage

//--- verilog/ssm_spi_script_master.sv
`timescale 1ns/1ps

// ==========================================================
// Command FIFO
module ssm_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];   // Storage words
  logic [AW-1:0] wp_q;       // Write pointer
  logic [AW-1:0] rp_q;       // Read pointer
  logic [AW:0] cnt_q;        // Fill level
  logic [AW:0] cnt_d;
  logic ready_q;             // Registered ready, so the port is a flop
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  // Next fill level
  always_comb begin
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointers and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(D));
    end
  end

  // Data words, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule

// ==========================================================
// Scripted SPI master
module ssm_spi_script_master
  import ssm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] cmd_data,
  output logic cmd_ready,
  input wire logic spi_miso_i,
  output logic spi_sclk_o,
  output logic spi_sclk_oe,
  output logic spi_mosi_o,
  output logic spi_mosi_oe,
  output logic [NUM_CS-1:0] spi_cs_o,
  output logic [NUM_CS-1:0] spi_cs_oe,
  input wire logic [5:0] rd_index,
  output logic [SAMPLE_W-1:0] rd_data_q,
  output logic [6:0] read_count_q,
  output logic busy_q,
  output logic done_q,
  output logic done_err_q
);

  // ==========================================================
  // Declarations
  logic [1:0] rst_sync_q;       // Reset release synchroniser
  logic rst_n;                  // Synchronised reset
  logic miso_meta_q;            // First stage, read only by second
  logic miso_q;                 // Synchronised data in
  ssm_state_t st_q;             // Sequencer state
  logic [CMD_W-1:0] cmd_q;      // Command being executed
  logic f_valid;
  logic f_ready;
  logic [CMD_W-1:0] f_data;
  logic [3:0] op;
  logic [2:0] sel;
  logic [15:0] arg;
  logic cpol_q;                 // Clock idle level
  logic cpha_q;                 // Sample on trailing edge when set
  logic [15:0] half_q;          // Half period in cycles
  logic [4:0] bits_q;           // Script sample width
  logic oe_q;                   // Port driven
  logic [NUM_CS-1:0] cs_q;      // Select levels
  logic basic_q;                // Running a basic transaction
  logic [7:0] left_q;           // Basic bytes after the current one
  logic [15:0] wait_q;          // Lead/tail countdown
  logic [15:0] hcnt_q;          // Half period countdown
  logic [4:0] edge_q;           // Clock edge number in sample
  logic [4:0] nb_q;             // Width of current sample
  logic [15:0] tx_q;            // Outgoing bits, msb first
  logic [15:0] rx_q;            // Incoming bits
  logic [15:0] rx_next;
  logic [15:0] tx_load;
  logic [15:0] ld_data;
  logic [4:0] ld_bits;
  logic sclk_q;
  logic mosi_q;
  logic [6:0] reads_q;          // Reads used in this script
  logic err_q;                  // Read limit hit in this script
  logic [SAMPLE_W-1:0] rmem_q [MAX_READS];
  logic tick;
  logic sample_edge;
  logic last_edge;
  logic start_shift;
  logic reads_full;

  assign rst_n = rst_sync_q[1];
  assign op = cmd_q[OP_LSB +: 4];
  assign sel = cmd_q[CS_SEL_LSB +: 3];
  assign arg = cmd_q[ARG_LSB +: 16];
  assign reads_full = (reads_q == 7'(MAX_READS));
  assign tick = (st_q == ST_SHIFT) && (hcnt_q == 16'h0001);
  assign sample_edge = (edge_q[0] == cpha_q);
  assign last_edge = tick && (edge_q == 5'({nb_q, 1'b0} - 6'h01));

  // ==========================================================
  // Reset and input synchronisers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Data in crosses from the slave's timing, so two stages
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      miso_meta_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      miso_meta_q <= spi_miso_i;
      miso_q <= miso_meta_q;
    end
  end

  // ==========================================================
  // Command buffer
  ssm_fifo #(
    .W(CMD_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk_sys),
    .rst_n(rst_n),
    .in_valid(cmd_valid),
    .in_data(cmd_data),
    .in_ready(cmd_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  assign f_ready = (st_q == ST_IDLE) || (st_q == ST_BDATA);

  // ==========================================================
  // Shift load values
  always_comb begin
    ld_data = (st_q == ST_BDATA) ? {8'h00, f_data[7:0]} : arg;
    ld_bits = (st_q == ST_BDATA) ? BASIC_BITS : bits_q;
    // Left-align the sample so the msb leaves first
    tx_load = 16'(ld_data << (5'h10 - ld_bits));
    rx_next = sample_edge ? {rx_q[14:0], miso_q} : rx_q;
  end

  // A new sample starts from a write-read or a basic data byte
  assign start_shift = ((st_q == ST_DECODE) && (op == OP_WRRD) && !reads_full) ||
                       ((st_q == ST_BDATA) && f_valid);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cmd_q <= '0;
      basic_q <= 1'b0;
      left_q <= 8'h00;
      wait_q <= 16'h0000;
    end else begin
      case (st_q)
        // Take the next command
        ST_IDLE: begin
          if (f_valid) begin
            cmd_q <= f_data;
            st_q <= ST_DECODE;
          end
        end
        // Single-cycle commands end here
        ST_DECODE: begin
          if (op == OP_WRRD && !reads_full) begin
            basic_q <= 1'b0;
            st_q <= ST_SHIFT;
          end else if (op == OP_BASIC) begin
            basic_q <= 1'b1;
            left_q <= arg[7:0];
            wait_q <= 16'(CS_LEAD_CYC - 1);
            st_q <= ST_LEAD;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        // Select asserted, waiting out the lead time
        ST_LEAD: begin
          if (wait_q == 16'h0000) begin
            st_q <= ST_BDATA;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        // Waiting for the next data byte of a basic transaction
        ST_BDATA: begin
          if (f_valid) begin
            st_q <= ST_SHIFT;
          end
        end
        // Serial exchange of one sample
        ST_SHIFT: begin
          if (last_edge) begin
            if (!basic_q) begin
              st_q <= ST_IDLE;
            end else if (left_q == 8'h00) begin
              wait_q <= 16'(CS_TAIL_CYC - 1);
              st_q <= ST_TAIL;
            end else begin
              left_q <= left_q - 8'h01;
              st_q <= ST_BDATA;
            end
          end
        end
        // Tail time, then release
        ST_TAIL: begin
          if (wait_q == 16'h0000) begin
            st_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Port configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpol_q <= RST_CPOL;
      cpha_q <= RST_CPHA;
      half_q <= RST_HALF;
      bits_q <= RST_BITS;
    end else if (st_q == ST_DECODE) begin
      if (op == OP_POLPHA) begin
        cpol_q <= arg[CPOL_BIT];
        cpha_q <= arg[CPHA_BIT];
      end else if (op == OP_RATE) begin
        // zero is taken as one cycle
        half_q <= (arg == 16'h0000) ? 16'h0001 : arg;
      end else if (op == OP_BITS) begin
        // width clamped to 1..16
        // Whole argument tested, so 32 or 48 clamp high, not low
        if (arg == 16'h0000) begin
          bits_q <= 5'h01;
        end else if (arg > 16'h0010) begin
          bits_q <= 5'h10;
        end else begin
          bits_q <= arg[4:0];
        end
      end
    end
  end

  // ==========================================================
  // Pin drive and chip selects
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
      cs_q <= '1;
    end else if (st_q == ST_DECODE) begin
      if (op == OP_ENABLE) begin
        oe_q <= 1'b1;
      end else if (op == OP_DISABLE) begin
        oe_q <= 1'b0;
      end else if (op == OP_CS_LOW || op == OP_BASIC) begin
        cs_q[sel] <= 1'b0;
      end else if (op == OP_CS_HIGH) begin
        cs_q[sel] <= 1'b1;
      end
    end else if (st_q == ST_TAIL && wait_q == 16'h0000) begin
      cs_q[sel] <= 1'b1;
    end
  end

  // ==========================================================
  // Serial shifter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= 16'h0000;
      edge_q <= 5'h00;
      nb_q <= RST_BITS;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      sclk_q <= RST_CPOL;
      mosi_q <= 1'b0;
    end else if (start_shift) begin
      hcnt_q <= half_q;
      edge_q <= 5'h00;
      nb_q <= ld_bits;
      rx_q <= 16'h0000;
      // Leading-edge sampling needs the first bit set up now
      if (!cpha_q) begin
        mosi_q <= tx_load[15];
        tx_q <= {tx_load[14:0], 1'b0};
      end else begin
        tx_q <= tx_load;
      end
    end else if (tick) begin
      hcnt_q <= half_q;
      edge_q <= edge_q + 5'h01;
      sclk_q <= ~sclk_q;
      // capture on sample edge, drive on the other
      if (sample_edge) begin
        rx_q <= rx_next;
      end else begin
        mosi_q <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end else if (st_q == ST_SHIFT) begin
      hcnt_q <= hcnt_q - 16'h0001;
    end else if (st_q == ST_DECODE && op == OP_POLPHA) begin
      // Idle level follows polarity at once
      sclk_q <= arg[CPOL_BIT];
    end
  end

  // ==========================================================
  // Read results and script bookkeeping
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reads_q <= 7'h00;
      err_q <= 1'b0;
      done_q <= 1'b0;
      done_err_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (st_q == ST_DECODE && op == OP_END) begin
        // Script boundary: report and start afresh
        done_q <= 1'b1;
        done_err_q <= err_q;
        reads_q <= 7'h00;
        err_q <= 1'b0;
      end else if (st_q == ST_DECODE && op == OP_WRRD && reads_full) begin
        err_q <= 1'b1;
      end else if (last_edge) begin
        if (reads_full) begin
          // basic byte beyond the limit not stored
          err_q <= 1'b1;
        end else begin
          reads_q <= reads_q + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (last_edge && !reads_full) begin
      rmem_q[reads_q[5:0]] <= rx_next;
    end
  end

  // ==========================================================
  // Registered status and readback
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
      read_count_q <= 7'h00;
      busy_q <= 1'b0;
    end else begin
      rd_data_q <= rmem_q[rd_index];
      read_count_q <= reads_q;
      busy_q <= (st_q != ST_IDLE);
    end
  end

  // Pin outputs, all straight from flops
  assign spi_sclk_o = sclk_q;
  assign spi_mosi_o = mosi_q;
  assign spi_cs_o = cs_q;
  assign spi_sclk_oe = oe_q;
  assign spi_mosi_oe = oe_q;
  assign spi_cs_oe = {NUM_CS{oe_q}};

endmodule

//--- verification/ssm_spi_script_master_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the scripted SPI master
module ssm_spi_script_master_monitor
  import ssm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic spi_miso_i,
  input wire logic spi_sclk_o,
  input wire logic spi_sclk_oe,
  input wire logic spi_mosi_o,
  input wire logic spi_mosi_oe,
  input wire logic [NUM_CS-1:0] spi_cs_o,
  input wire logic [NUM_CS-1:0] spi_cs_oe,
  input wire logic [5:0] rd_index,
  input wire logic [SAMPLE_W-1:0] rd_data_q,
  input wire logic [6:0] read_count_q,
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic done_err_q
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================
  // Pin ownership
  // idle after reset
  property p_rst_idle;
    $rose(arst_n) |-> !spi_sclk_oe && spi_cs_oe == 8'h00 && spi_cs_o == 8'hff;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("pins not idle after reset");
  property p_oe_eq;
    spi_cs_oe == {NUM_CS{spi_sclk_oe}} && spi_mosi_oe == spi_sclk_oe &&
    (!$changed(spi_sclk_oe) || busy_q);
  endproperty
  a_oe_eq: assert property (p_oe_eq)
    else $error("pin enables disagree");

  // ==========================================================
  // Bus quiet between commands
  // clock only when busy
  property p_sclk_busy;
    $changed(spi_sclk_o) |-> busy_q || $past(busy_q);
  endproperty
  a_sclk_busy: assert property (p_sclk_busy)
    else $error("serial clock moved while idle");
  property p_mosi_busy;
    $changed(spi_mosi_o) |-> busy_q || $past(busy_q);
  endproperty
  a_mosi_busy: assert property (p_mosi_busy)
    else $error("data line moved while idle");
  property p_done_pulse;
    done_q |=> !done_q;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_ready_hold;
    cmd_ready && !cmd_valid |=> cmd_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without a push");

  // ==========================================================
  // Result store
  // count ceiling
  property p_rd_max;
    read_count_q <= MAX_READS;
  endproperty
  a_rd_max: assert property (p_rd_max)
    else $error("more results than allowed");
  property p_rd_step;
    $changed(read_count_q) |-> read_count_q == $past(read_count_q) + 7'd1 || read_count_q == 7'd0;
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("result count jumped");
  property p_clr_end;
    done_q |-> ##[0:2] read_count_q == 7'd0;
  endproperty
  a_clr_end: assert property (p_clr_end)
    else $error("result count not cleared at end");
  property p_err_end;
    $changed(done_err_q) |-> done_q || $past(done_q);
  endproperty
  a_err_end: assert property (p_err_end)
    else $error("error flag moved outside end");

  // Main scenarios reached
  c_done: cover property (done_q);
  c_err: cover property (done_q ##1 done_err_q);
  c_full: cover property (!cmd_ready);
  c_limit: cover property (read_count_q == 7'd64);
endmodule

bind ssm_spi_script_master ssm_spi_script_master_monitor u_ssm_spi_script_master_monitor (
  .clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
  .cmd_ready(cmd_ready), .spi_miso_i(spi_miso_i), .spi_sclk_o(spi_sclk_o),
  .spi_sclk_oe(spi_sclk_oe), .spi_mosi_o(spi_mosi_o), .spi_mosi_oe(spi_mosi_oe),
  .spi_cs_o(spi_cs_o), .spi_cs_oe(spi_cs_oe), .rd_index(rd_index), .rd_data_q(rd_data_q),
  .read_count_q(read_count_q), .busy_q(busy_q), .done_q(done_q), .done_err_q(done_err_q));

//--- verification/ssm_slave_model.sv
`timescale 1ns/1ps
// ==========================================================
// Behavioural SPI slave on one select line
module ssm_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [4:0] bits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [15:0] sh; // Word being sent
  logic [15:0] rx; // Bits gathered, newest in bit 0
  int k; // Bits done in this frame
  initial begin
    miso = 1'b0;
    rx = 16'h0000;
    rx_word = 16'h0000;
    sh = 16'h0000;
    k = 0;
  end
  // Fresh frame on select; a released line shows the inverse, never a held value
  always @(cs_n) begin
    if (!cs_n) begin
      sh = reply;
      k = 0;
      if (!cpha) begin
        miso = sh[bits-1];
      end
    end else begin
      miso = ~miso;
    end
  end
  // Leading edge leaves the idle level; phase picks which edge samples
  always @(sclk) begin
    if (!cs_n) begin
      if ((sclk != cpol) != cpha) begin
        rx = {rx[14:0], mosi};
        k = k + 1;
        // Back-to-back frames reload at once so phase 0 has its first bit ready
        if (k == bits) begin
          rx_word = rx;
          sh = reply;
          k = 0;
        end
      end else if (k < bits) begin
        miso = sh[bits-1-k];
      end
    end
  end
endmodule

//--- verification/ssm_spi_script_master_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the scripted SPI master
module ssm_spi_script_master_tb_top;
  import ssm_pkg::*;
  logic clk_sys, arst_n, cmd_valid, cmd_ready, busy_q, done_q, done_err_q;
  logic spi_miso_i, spi_sclk_o, spi_sclk_oe, spi_mosi_o, spi_mosi_oe;
  logic [CMD_W-1:0] cmd_data;
  logic [NUM_CS-1:0] spi_cs_o, spi_cs_oe;
  logic [5:0] rd_index;
  logic [SAMPLE_W-1:0] rd_data_q;
  logic [6:0] read_count_q, last_cnt;
  logic cpol, cpha, cs_prev, sclk_prev, first;
  logic [4:0] sbits; // Sample width the slave expects
  logic [15:0] reply, rx_word, lfsr, mask;
  logic [15:0] exp_rd[$]; // Expected results, oldest first
  logic exp_err[$]; // Expected error flag per end
  int err_count, n_checks, refused, edges, e0, cyc, t_cs, t_edge, lead_n, tail_n, gap_n;

  ssm_spi_script_master u_ssm_spi_script_master (.clk_sys(clk_sys), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .spi_miso_i(spi_miso_i), .spi_sclk_o(spi_sclk_o), .spi_sclk_oe(spi_sclk_oe),
    .spi_mosi_o(spi_mosi_o), .spi_mosi_oe(spi_mosi_oe), .spi_cs_o(spi_cs_o),
    .spi_cs_oe(spi_cs_oe), .rd_index(rd_index), .rd_data_q(rd_data_q),
    .read_count_q(read_count_q), .busy_q(busy_q), .done_q(done_q), .done_err_q(done_err_q));
  // Released lines: clock rests at idle, select pulled up
  ssm_slave_model u_ssm_slave_model (.sclk(spi_sclk_oe ? spi_sclk_o : cpol),
    .mosi(spi_mosi_o), .cs_n(spi_cs_oe[0] ? spi_cs_o[0] : 1'b1), .cpol(cpol), .cpha(cpha),
    .bits(sbits), .reply(reply), .miso(spi_miso_i), .rx_word(rx_word));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] next_rnd(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Offer one word and hold it until the buffer takes it
  task automatic push(input logic [3:0] op, input logic [2:0] sel, input logic [15:0] arg);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_data = {op, 1'b0, sel, 8'h00, arg};
    while (cmd_ready !== 1'b1) begin
      refused++;
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
  endtask
  // Wait until the script has drained
  task automatic settle;
    int quiet;
    int n;
    quiet = 0;
    n = 0;
    while (quiet < 4 && n < 20000) begin
      @(posedge clk_sys);
      #1;
      n++;
      quiet = (busy_q === 1'b0) ? quiet + 1 : 0;
    end
  endtask
  task automatic wrrd(input logic [15:0] arg);
    mask = 16'hffff >> (16 - sbits);
    exp_rd.push_back(reply & mask);
    push(OP_WRRD, 3'h0, arg & mask);
  endtask
  task automatic complete_run;
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchers: results, end status, edge timing
  always @(posedge clk_sys) begin
    #1;
    if (read_count_q !== last_cnt) begin
      last_cnt = read_count_q;
      if (read_count_q !== 7'd0) begin
        rd_index = read_count_q[5:0] - 6'd1;
        @(posedge clk_sys);
        #1;
        check("rd_data", exp_rd.size() ? exp_rd.pop_front() : 16'hxxxx, rd_data_q);
      end
    end
  end
  always @(posedge clk_sys) begin
    #1;
    if (done_q === 1'b1) begin
      @(posedge clk_sys);
      #1;
      check("done_err", {15'h0, exp_err.size() ? exp_err.pop_front() : 1'bx}, {15'h0, done_err_q});
    end
  end
  always @(posedge clk_sys) begin
    #1;
    cyc++;
    if (cs_prev === 1'b1 && spi_cs_o[0] === 1'b0) begin
      t_cs = cyc;
      first = 1'b1;
    end
    if (cs_prev === 1'b0 && spi_cs_o[0] === 1'b1) begin
      tail_n = cyc - t_edge;
    end
    if (spi_sclk_o !== sclk_prev) begin
      edges++;
      gap_n = cyc - t_edge;
      t_edge = cyc;
      if (first) begin
        lead_n = cyc - t_cs;
      end
      first = 1'b0;
    end
    cs_prev = spi_cs_o[0];
    sclk_prev = spi_sclk_o;
  end
  // Cut a hang short
  initial begin
    #(20 * 60000);
    err_count++;
    complete_run;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {cmd_valid, cmd_data, rd_index, cpol, cpha, reply, last_cnt} = '0;
    {err_count, n_checks, refused, edges, cyc, t_cs, t_edge, lead_n, tail_n, gap_n} = '0;
    {cs_prev, sclk_prev, first} = 3'b100;
    sbits = 5'd8;
    lfsr = 16'h0047;
    arst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("cs_idle", 16'h00ff, {spi_cs_oe, spi_cs_o});
    push(OP_ENABLE, 3'h0, 16'h0000);
    settle;
    check("pins_on", 16'hff01, {spi_cs_oe, 7'h00, spi_sclk_oe});
    for (int s = 1; s < 8; s++) begin
      push(OP_CS_LOW, s[2:0], 16'h0000);
      settle;
      check("cs_low", 16'h0000, {15'h0, spi_cs_o[s]});
      push(OP_CS_HIGH, s[2:0], 16'h0000);
      settle;
      check("cs_high", 16'h0001, {15'h0, spi_cs_o[s]});
    end
    // Every clock mode, each with its own rate and width
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} = m[1:0];
      sbits = 5'(m * 4 + 4);
      lfsr = next_rnd(lfsr);
      reply = lfsr;
      push(OP_POLPHA, 3'h0, 16'(m));
      push(OP_RATE, 3'h0, 16'(m + 4));
      push(OP_BITS, 3'h0, (m == 3) ? 16'h0020 : 16'(sbits));
      push(OP_CS_LOW, 3'h0, 16'h0000);
      settle;
      check("sclk_idle", {15'h0, cpol}, {15'h0, spi_sclk_o});
      lfsr = next_rnd(lfsr);
      wrrd(lfsr);
      push(OP_CS_HIGH, 3'h0, 16'h0000);
      settle;
      check("slave_rx", lfsr & mask, rx_word & mask);
      check("half_period", 16'(m + 4), gap_n[15:0]);
    end
    // Basic two-byte exchange on select 0
    sbits = 5'd8;
    lfsr = next_rnd(lfsr);
    reply = lfsr;
    exp_rd.push_back({8'h00, reply[7:0]});
    exp_rd.push_back({8'h00, reply[7:0]});
    push(OP_BASIC, 3'h0, 16'h0001);
    push(4'h0, 3'h0, 16'h005a);
    push(4'h0, 3'h0, {8'h00, lfsr[15:8]});
    settle;
    check("lead", 16'h0001, {15'h0, lead_n >= 250 && lead_n <= 770});
    check("tail", 16'h0001, {15'h0, tail_n >= 370 && tail_n <= 412});
    check("basic_rx", {8'h00, lfsr[15:8]}, rx_word & 16'h00ff);
    exp_err.push_back(1'b0);
    push(OP_END, 3'h0, 16'h0000);
    settle;
    // One read past the limit, pushed back to back so the buffer fills
    push(OP_BITS, 3'h0, 16'h0008);
    push(OP_CS_LOW, 3'h0, 16'h0000);
    settle;
    e0 = edges;
    refused = 0;
    for (int i = 0; i < 65; i++) begin
      lfsr = next_rnd(lfsr);
      if (i < 64) begin
        wrrd(lfsr);
      end else begin
        push(OP_WRRD, 3'h0, lfsr);
      end
    end
    exp_err.push_back(1'b1);
    push(OP_END, 3'h0, 16'h0000);
    push(OP_CS_HIGH, 3'h0, 16'h0000);
    settle;
    check("edge_count", 16'd1024, 16'(edges - e0));
    check("buffer_full", 16'h0001, {15'h0, refused > 0});
    push(OP_DISABLE, 3'h0, 16'h0000);
    settle;
    check("pins_off", 16'h0000, {spi_cs_oe, 6'h00, spi_mosi_oe, spi_sclk_oe});
    check("pending", 16'h0000, 16'(exp_rd.size() + exp_err.size()));
    complete_run;
  end
endmodule
